// file: hw/gdcr_pkg.sv
// constants and types shared by the gate driver configuration registers
package gdcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0]  CHIP_CTRL_THREE_ADDR  = 8'h1c;
    localparam logic [7:0]  GD_CTRL_ONE_ADDR      = 8'h1e;
    localparam logic [15:0] CHIP_CTRL_THREE_RESET = 16'h0009;
    localparam logic [15:0] GD_CTRL_ONE_RESET     = 16'h0138;
    localparam logic [15:0] CHIP_CTRL_THREE_MASK  = 16'h570b;
    localparam logic [15:0] GD_CTRL_ONE_MASK      = 16'h77bc;

    ////////////////////////////////////////////////////////////////////////
    // chip_control_three fields
    localparam int unsigned WARN_REPORT_BIT = 14;
    localparam int unsigned SSC_OFF_BIT     = 12;
    localparam int unsigned TRICKLE_DLY_BIT = 10;
    localparam int unsigned HS_PD_BIT       = 9;
    localparam int unsigned LS_PD_BIT       = 8;
    localparam int unsigned OT_GRADE_BIT    = 3;
    localparam int unsigned OT_MODE_LSB     = 0;

    ////////////////////////////////////////////////////////////////////////
    // gate_drive_control_one fields
    localparam int unsigned PWM_MODE_LSB = 12;
    localparam int unsigned PROFILE_LSB  = 9;

    ////////////////////////////////////////////////////////////////////////
    // codes
    localparam logic [1:0] OT_WARN     = 2'b00;
    localparam logic [1:0] OT_FAULT    = 2'b01;
    localparam logic [1:0] PROF_FIXED  = 2'b00;
    localparam logic [1:0] PROF_DYN    = 2'b01;
    localparam logic [2:0] PWM_SIX_A   = 3'b000;
    localparam logic [2:0] PWM_THREE_P = 3'b001;
    localparam logic [2:0] PWM_THREE_R = 3'b010;
    localparam logic [2:0] PWM_SINGLE  = 3'b011;
    localparam logic [2:0] PWM_RSVD    = 3'b100;
    localparam logic [2:0] PWM_REG_GD  = 3'b101;
    localparam logic [2:0] PWM_SIX_B   = 3'b110;
    localparam logic [2:0] PWM_SIX_C   = 3'b111;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_FREQ_MHZ      = 200;
    localparam int unsigned TRICKLE_SHORT_US  = 100;
    localparam int unsigned TRICKLE_LONG_US   = 250;
    localparam int unsigned TRICKLE_SHORT_CYC =
        TRICKLE_SHORT_US * CLK_FREQ_MHZ;
    localparam int unsigned TRICKLE_LONG_CYC  =
        TRICKLE_LONG_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {TP_IDLE, TP_WAIT, TP_ON} gdcr_tp_state_t;

endpackage

// file: hw/gdcr_trickle_timer.sv
// delay from pwm idle to trickle pump activation
`timescale 1ns/10ps
`default_nettype none
module gdcr_trickle_timer
#(
    parameter int unsigned SHORT_CYC = gdcr_pkg::TRICKLE_SHORT_CYC,
    parameter int unsigned LONG_CYC  = gdcr_pkg::TRICKLE_LONG_CYC
)
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pwm_idle_in,
    input  wire logic long_sel_in,
    output var  logic pump_on_out
);
    import gdcr_pkg::*;

    localparam int unsigned CW = $clog2(LONG_CYC + 1);

    generate
        if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC)
        begin : g_chk
            $error("trickle delay counts out of range");
        end
    endgenerate

    typedef struct packed {
        gdcr_tp_state_t st;
        logic [CW-1:0]  cnt;
        logic           on;
    } gdcr_tp_t;

    gdcr_tp_t      s_q;
    gdcr_tp_t      s_d;
    logic [CW-1:0] target_w;

    assign target_w = long_sel_in ? CW'(LONG_CYC) : CW'(SHORT_CYC);

    ////////////////////////////////////////////////////////////////////////
    // idle timer
    always_comb
    begin
        s_d = s_q;
        if (!pwm_idle_in)
        begin
            s_d.st  = TP_IDLE;
            s_d.cnt = '0;
            s_d.on  = 1'b0;
        end
        else
        begin
            case (s_q.st)
                TP_IDLE:
                begin
                    s_d.st  = TP_WAIT;
                    s_d.cnt = CW'(1);
                end
                TP_WAIT:
                begin
                    if (s_q.cnt >= target_w)
                    begin
                        s_d.st = TP_ON;
                        s_d.on = 1'b1;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt + CW'(1);
                    end
                end
                default:
                begin
                    s_d.on = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '{st: TP_IDLE, cnt: '0, on: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pump_on_out = s_q.on;

    ////////////////////////////////////////////////////////////////////////
    // checks
    pump_on_delay_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        $rose(pump_on_out) |-> $past(s_q.cnt) >= $past(target_w))
        else $error("trickle pump on before delay elapsed");

    pump_busy_off_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !pwm_idle_in |=> !pump_on_out)
        else $error("trickle pump on while pwm active");

endmodule
`default_nettype wire

// file: hw/gdcr_gate_mux.sv
// pwm input scheme decoder for three phases
`timescale 1ns/10ps
`default_nettype none
module gdcr_gate_mux
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] mode_in,
    input  wire logic [2:0] high_in_x,
    input  wire logic [2:0] low_in_x,
    input  wire logic [2:0] phase_en_in,
    input  wire logic [2:0] reg_high_in,
    input  wire logic [2:0] reg_low_in,
    input  wire logic       force_off_in,
    output var  logic [2:0] high_gate_out,
    output var  logic [2:0] low_gate_out
);
    import gdcr_pkg::*;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } gdcr_gm_t;

    gdcr_gm_t   s_q;
    gdcr_gm_t   s_d;
    logic [2:0] hi_w;
    logic [2:0] lo_w;

    function automatic logic [1:0] gdcr_phase_drive(
        input logic [2:0] mode,
        input logic       hi,
        input logic       lo,
        input logic       en,
        input logic       pwm,
        input logic       rh,
        input logic       rl);
        logic [1:0] r;
        r = 2'b00;
        case (mode)
            PWM_SIX_A, PWM_SIX_B, PWM_SIX_C: r = {hi, lo};
            PWM_THREE_P: r = {hi & lo, ~hi & lo};
            PWM_THREE_R: r = {hi & en, ~hi & en};
            PWM_SINGLE:  r = {pwm & lo, ~pwm & lo};
            PWM_REG_GD:  r = {rh, rl};
            default:     r = 2'b00;
        endcase
        if (r == 2'b11)
        begin
            r = 2'b00;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-phase decode
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ph
            assign {hi_w[gi], lo_w[gi]} = gdcr_phase_drive(mode_in,
                high_in_x[gi], low_in_x[gi], phase_en_in[gi], high_in_x[0],
                reg_high_in[gi], reg_low_in[gi]);
        end
    endgenerate

    always_comb
    begin
        s_d.hi = force_off_in ? 3'h0 : hi_w;
        s_d.lo = force_off_in ? 3'h0 : lo_w;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '{hi: 3'h0, lo: 3'h0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign high_gate_out = s_q.hi;
    assign low_gate_out  = s_q.lo;

    ////////////////////////////////////////////////////////////////////////
    // checks
    six_follow_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (mode_in == PWM_SIX_B && !force_off_in
         && (high_in_x & low_in_x) == 3'h0)
        |=> high_gate_out == $past(high_in_x)
            && low_gate_out == $past(low_in_x))
        else $error("six-input mode gates do not follow inputs");

    reg_en_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (mode_in == PWM_THREE_R && !force_off_in)
        |=> low_gate_out == (~$past(high_in_x) & $past(phase_en_in)))
        else $error("register-enable mode low gates wrong");

    rsvd_low_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (mode_in == PWM_RSVD)
        |=> high_gate_out == 3'h0 && low_gate_out == 3'h0)
        else $error("reserved pwm mode drives gates");

    reg_drive_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (mode_in == PWM_REG_GD && !force_off_in
         && (reg_high_in & reg_low_in) == 3'h0)
        |=> high_gate_out == $past(reg_high_in))
        else $error("register gate drive high gates wrong");

endmodule
`default_nettype wire

// file: hw/gdcr_top.sv
// gate driver configuration registers and their control outputs
`timescale 1ns/10ps
`default_nettype none
module gdcr_top
#(
    parameter int unsigned TIMING_W  = 4,
    parameter int unsigned SHORT_CYC = gdcr_pkg::TRICKLE_SHORT_CYC,
    parameter int unsigned LONG_CYC  = gdcr_pkg::TRICKLE_LONG_CYC
)
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic                reg_wr_in,
    input  wire logic [15:0]         reg_wdata_in,
    input  wire logic                reg_rd_in,
    output var  logic [15:0]         reg_rdata_out,
    input  wire logic                warn_event_in,
    input  wire logic                fault_event_in,
    input  wire logic                overtemp_in,
    input  wire logic                clear_fault_in,
    input  wire logic                driver_kill_pin_in,
    input  wire logic [2:0]          high_in_x,
    input  wire logic [2:0]          low_in_x,
    input  wire logic [2:0]          phase_drive_enable_bit_in,
    input  wire logic [2:0]          reg_high_gate_cmd_in,
    input  wire logic [2:0]          reg_low_gate_cmd_in,
    input  wire logic [TIMING_W-1:0] dynamic_sink_timing_in,
    output var  logic                fault_out_n,
    output var  logic                warn_flag_out,
    output var  logic                fault_flag_out,
    output var  logic                overtemp_shutdown_out,
    output var  logic                overtemp_grade_sel_out,
    output var  logic                spread_spectrum_off_out,
    output var  logic                trickle_pump_on_out,
    output var  logic                hs_pulldown_passive_out,
    output var  logic                hs_pulldown_semi_out,
    output var  logic                ls_pulldown_passive_out,
    output var  logic                ls_pulldown_semi_out,
    output var  logic [2:0]          high_gate_x_out,
    output var  logic [2:0]          low_gate_x_out,
    output var  logic                dynamic_timing_en_out,
    output var  logic [TIMING_W-1:0] dynamic_sink_timing_out
);
    import gdcr_pkg::*;

    generate
        if (TIMING_W < 1 || TIMING_W > 8)
        begin : g_chk
            $error("dynamic sink timing width out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [15:0]         gd;
        logic [15:0]         cc;
        logic [15:0]         rdata;
        logic                warn_flag;
        logic                fault_flag;
        logic                ot_shut;
        logic                fault_n;
        logic                ssc_off;
        logic                grade;
        logic                hs_pas;
        logic                hs_semi;
        logic                ls_pas;
        logic                ls_semi;
        logic                dyn_en;
        logic [TIMING_W-1:0] dyn_t;
    } gdcr_top_t;

    gdcr_top_t  s_q;
    gdcr_top_t  s_d;
    logic       wr_gd_w;
    logic       wr_cc_w;
    logic [1:0] ot_mode_w;
    logic       ot_warn_w;
    logic       ot_fault_w;
    logic       pwm_idle_w;
    logic       gate_off_w;

    assign wr_gd_w    = reg_wr_in && reg_addr_in == GD_CTRL_ONE_ADDR;
    assign wr_cc_w    = reg_wr_in && reg_addr_in == CHIP_CTRL_THREE_ADDR;
    assign ot_mode_w  = s_q.cc[OT_MODE_LSB +: 2];
    assign ot_warn_w  = overtemp_in && ot_mode_w == OT_WARN;
    assign ot_fault_w = overtemp_in && ot_mode_w == OT_FAULT;
    assign pwm_idle_w = (high_in_x | low_in_x) == 3'h0;
    assign gate_off_w = driver_kill_pin_in || s_q.fault_flag;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d = s_q;
        // register writes keep only defined fields
        if (wr_gd_w)
        begin
            s_d.gd = reg_wdata_in & GD_CTRL_ONE_MASK;
        end
        if (wr_cc_w)
        begin
            s_d.cc = reg_wdata_in & CHIP_CTRL_THREE_MASK;
        end
        // read data; unmapped addresses read zero
        if (reg_rd_in)
        begin
            if (reg_addr_in == GD_CTRL_ONE_ADDR)
            begin
                s_d.rdata = s_q.gd;
            end
            else if (reg_addr_in == CHIP_CTRL_THREE_ADDR)
            begin
                s_d.rdata = s_q.cc;
            end
            else
            begin
                s_d.rdata = 16'h0000;
            end
        end
        // sticky flags; a new event beats the clear
        if (clear_fault_in)
        begin
            s_d.warn_flag  = 1'b0;
            s_d.fault_flag = 1'b0;
            s_d.ot_shut    = 1'b0;
        end
        if (warn_event_in || ot_warn_w)
        begin
            s_d.warn_flag = 1'b1;
        end
        if (fault_event_in || ot_fault_w)
        begin
            s_d.fault_flag = 1'b1;
        end
        if (ot_fault_w)
        begin
            s_d.ot_shut = 1'b1;
        end
        s_d.fault_n = ~(s_d.fault_flag
                      || (s_d.warn_flag && s_q.cc[WARN_REPORT_BIT]));
        // configuration outputs
        s_d.ssc_off = s_q.cc[SSC_OFF_BIT];
        s_d.grade   = s_q.cc[OT_GRADE_BIT];
        s_d.hs_pas  = driver_kill_pin_in && s_q.cc[HS_PD_BIT];
        s_d.hs_semi = driver_kill_pin_in && !s_q.cc[HS_PD_BIT];
        s_d.ls_pas  = driver_kill_pin_in && s_q.cc[LS_PD_BIT];
        s_d.ls_semi = driver_kill_pin_in && !s_q.cc[LS_PD_BIT];
        // drive-current profile
        if (s_q.gd[PROFILE_LSB +: 2] == PROF_DYN)
        begin
            s_d.dyn_en = 1'b1;
            s_d.dyn_t  = dynamic_sink_timing_in;
        end
        else
        begin
            s_d.dyn_en = 1'b0;
            s_d.dyn_t  = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '{gd: GD_CTRL_ONE_RESET,
                     cc: CHIP_CTRL_THREE_RESET,
                     rdata: 16'h0000,
                     warn_flag: 1'b0,
                     fault_flag: 1'b0,
                     ot_shut: 1'b0,
                     fault_n: 1'b1,
                     ssc_off: 1'b0,
                     grade: 1'b0,
                     hs_pas: 1'b0,
                     hs_semi: 1'b0,
                     ls_pas: 1'b0,
                     ls_semi: 1'b0,
                     dyn_en: 1'b0,
                     dyn_t: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks
    gdcr_trickle_timer #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) gdcr_trickle_timer_inst (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .pwm_idle_in (pwm_idle_w),
        .long_sel_in (s_q.cc[TRICKLE_DLY_BIT]),
        .pump_on_out (trickle_pump_on_out)
    );

    gdcr_gate_mux gdcr_gate_mux_inst (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .mode_in       (s_q.gd[PWM_MODE_LSB +: 3]),
        .high_in_x     (high_in_x),
        .low_in_x      (low_in_x),
        .phase_en_in   (phase_drive_enable_bit_in),
        .reg_high_in   (reg_high_gate_cmd_in),
        .reg_low_in    (reg_low_gate_cmd_in),
        .force_off_in  (gate_off_w),
        .high_gate_out (high_gate_x_out),
        .low_gate_out  (low_gate_x_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out           = s_q.rdata;
    assign fault_out_n             = s_q.fault_n;
    assign warn_flag_out           = s_q.warn_flag;
    assign fault_flag_out          = s_q.fault_flag;
    assign overtemp_shutdown_out   = s_q.ot_shut;
    assign overtemp_grade_sel_out  = s_q.grade;
    assign spread_spectrum_off_out = s_q.ssc_off;
    assign hs_pulldown_passive_out = s_q.hs_pas;
    assign hs_pulldown_semi_out    = s_q.hs_semi;
    assign ls_pulldown_passive_out = s_q.ls_pas;
    assign ls_pulldown_semi_out    = s_q.ls_semi;
    assign dynamic_timing_en_out   = s_q.dyn_en;
    assign dynamic_sink_timing_out = s_q.dyn_t;

    ////////////////////////////////////////////////////////////////////////
    // checks
    warn_sets_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        warn_event_in |=> warn_flag_out)
        else $error("warning event did not set flag");

    fault_pin_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        ##1 fault_out_n == !(fault_flag_out || (warn_flag_out
                           && $past(s_q.cc[WARN_REPORT_BIT]))))
        else $error("fault pin does not match flags and report select");

    ssc_off_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        ##1 spread_spectrum_off_out == $past(s_q.cc[SSC_OFF_BIT]))
        else $error("spread spectrum output wrong");

    pulldown_sel_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (driver_kill_pin_in && !s_q.cc[HS_PD_BIT])
        |=> hs_pulldown_semi_out && !hs_pulldown_passive_out)
        else $error("high-side pulldown choice wrong");

    ls_pulldown_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (driver_kill_pin_in && s_q.cc[LS_PD_BIT])
        |=> ls_pulldown_passive_out && !ls_pulldown_semi_out)
        else $error("low-side pulldown choice wrong");

    ot_fault_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (overtemp_in && ot_mode_w == OT_FAULT) |=> overtemp_shutdown_out
        ##1 (high_gate_x_out == 3'h0 && low_gate_x_out == 3'h0))
        else $error("overtemp fault mode did not shut down");

    ot_silent_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (overtemp_in && ot_mode_w[1] && !warn_event_in && !fault_event_in
         && !warn_flag_out && !fault_flag_out)
        |=> !warn_flag_out && !fault_flag_out)
        else $error("overtemp reported in no-report mode");

    profile_fixed_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (s_q.gd[PROFILE_LSB +: 2] == PROF_FIXED)
        |=> !dynamic_timing_en_out && dynamic_sink_timing_out == '0)
        else $error("sink timing applied in fixed profile");

    gd_reset_a: assert property (@(posedge clk_in)
        rst_in |=> s_q.gd == GD_CTRL_ONE_RESET)
        else $error("gate control register reset value wrong");

    rsvd_zero_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        reg_rdata_out[15] == 1'b0 && reg_rdata_out[11] == 1'b0
        && reg_rdata_out[6] == 1'b0)
        else $error("reserved bit read as one");

endmodule
`default_nettype wire

// file: test/gdcr_host_model.sv
// host model driving register port and pwm inputs
`timescale 1ns/10ps
`default_nettype none
module gdcr_host_model
(
    input  wire logic        clk_in,
    input  wire logic [15:0] rdata_in,
    output var  logic [7:0]  addr_out,
    output var  logic        wr_out,
    output var  logic [15:0] wdata_out,
    output var  logic        rd_out,
    output var  logic [2:0]  hi_out,
    output var  logic [2:0]  lo_out
);
    initial {addr_out, wr_out, wdata_out, rd_out, hi_out, lo_out} = '0;
    task automatic write_reg(logic [7:0] a, logic [15:0] d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    task automatic read_reg(logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(posedge clk_in);
        #1;
        d = rdata_in;
    endtask
    // the gate mux blanks both-on phases, so any pwm code is allowed
    task automatic set_pwm(logic [2:0] h, logic [2:0] l);
        @(posedge clk_in);
        hi_out <= h;
        lo_out <= l;
    endtask
endmodule
`default_nettype wire

// file: test/test_gdcr_top.sv
// bench for the gate driver configuration registers
`timescale 1ns/10ps
`default_nettype none
module test_gdcr_top;
    logic clk_in, rst_in, warn, flt, ot, clr, kill, wr, rd, fo_n, wf, ff;
    logic sd, grd, ssc, pump, hp, hs, lp, ls, den;
    logic [7:0]  addr;
    logic [15:0] wd, rdat;
    logic [2:0]  hi, lo, gh, gl;
    logic [2:0]  en = 3'h5, rgh = 3'h2, rgl = 3'h4;
    logic [3:0]  tin, tout;
    int bad_count = 0;
    int samples_checked = 0;
    gdcr_top #(.SHORT_CYC(20), .LONG_CYC(50)) gdcr_top_inst (.clk_in,
        .rst_in, .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .warn_event_in(warn),
        .fault_event_in(flt), .overtemp_in(ot), .clear_fault_in(clr),
        .driver_kill_pin_in(kill), .high_in_x(hi), .low_in_x(lo),
        .phase_drive_enable_bit_in(en), .reg_high_gate_cmd_in(rgh),
        .reg_low_gate_cmd_in(rgl), .dynamic_sink_timing_in(tin),
        .fault_out_n(fo_n), .warn_flag_out(wf), .fault_flag_out(ff),
        .overtemp_shutdown_out(sd), .overtemp_grade_sel_out(grd),
        .spread_spectrum_off_out(ssc), .trickle_pump_on_out(pump),
        .hs_pulldown_passive_out(hp), .hs_pulldown_semi_out(hs),
        .ls_pulldown_passive_out(lp), .ls_pulldown_semi_out(ls),
        .high_gate_x_out(gh), .low_gate_x_out(gl),
        .dynamic_timing_en_out(den), .dynamic_sink_timing_out(tout));
    gdcr_host_model gdcr_host_model_inst (.clk_in, .rdata_in(rdat),
        .addr_out(addr), .wr_out(wr), .wdata_out(wd), .rd_out(rd),
        .hi_out(hi), .lo_out(lo));
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic complete_run();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(string n, logic [15:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one-cycle pulse on {warn, fault, overtemp, clear}
    task automatic ev(logic [3:0] v);
        @(posedge clk_in);
        {warn, flt, ot, clr} <= v;
        @(posedge clk_in);
        {warn, flt, ot, clr} <= 4'h0;
        tick(2);
    endtask
    task automatic wreg(logic [7:0] a, logic [15:0] d);
        gdcr_host_model_inst.write_reg(a, d);
        tick(4);
    endtask
    task automatic rdc(string n, logic [7:0] a, logic [15:0] e);
        logic [15:0] d;
        gdcr_host_model_inst.read_reg(a, d);
        check(n, e, d);
    endtask
    task automatic t_regs();
        rdc("gd", 8'h1e, 16'h0138);
        rdc("cc", 8'h1c, 16'h0009);
        check("grade", 1, grd);
        wreg(8'h1c, 16'hffff);
        rdc("cc", 8'h1c, 16'h570b);
        wreg(8'h1e, 16'hffff);
        rdc("gd", 8'h1e, 16'h77bc);
        wreg(8'h12, 16'hffff);
        rdc("none", 8'h12, 16'h0);
    endtask
    task automatic t_warn();
        for (int i = 0; i < 4; i++)
        begin
            wreg(8'h1c, 16'(i));
            check("grade", 0, grd);
            ev(4'h1);
            ev(4'h2);
            check("warn", 16'(i == 0), wf);
            check("flt", 16'(i == 1), ff);
            check("sd", 16'(i == 1), sd);
            check("pin", 16'(i != 1), fo_n);
        end
        wreg(8'h1c, 16'h4000);
        ev(4'h1);
        ev(4'h8);
        check("pin", 0, fo_n);
        ev(4'h1);
        ev(4'h9);
        check("warn", 1, wf);
        ev(4'h1);
    endtask
    task automatic t_pd();
        for (int i = 0; i < 2; i++)
        begin
            wreg(8'h1c, i ? 16'h1201 : 16'h0101);
            @(posedge clk_in);
            kill <= 1'b1;
            tick(3);
            check("ssc", 16'(i), ssc);
            check("pd", i ? 16'h9 : 16'h6, {hp, hs, lp, ls});
            @(posedge clk_in);
            kill <= 1'b0;
            tick(3);
            check("pd", 0, {hp, hs, lp, ls});
        end
    endtask
    task automatic t_pump();
        for (int i = 0; i < 2; i++)
        begin
            wreg(8'h1c, 16'(i) << 10);
            gdcr_host_model_inst.set_pwm(3'h1, 3'h0);
            tick(3);
            check("pump", 0, pump);
            gdcr_host_model_inst.set_pwm(3'h0, 3'h0);
            tick(i ? 49 : 19);
            check("pump", 0, pump);
            tick(4);
            check("pump", 1, pump);
        end
    endtask
    // {mode, low inputs, high gates, low gates}; high inputs 001
    task automatic t_pwm();
        logic [11:0] t [9] = '{12'h18e, 12'hd8e, 12'hf8e, 12'h386,
            12'h58c, 12'h40c, 12'h7b0, 12'hb94, 12'h980};
        foreach (t[i])
        begin
            wreg(8'h1e, {1'b0, t[i][11:9], 12'h0});
            gdcr_host_model_inst.set_pwm(3'h1, t[i][8:6]);
            tick(3);
            check("gates", t[i][5:0], {gh, gl});
        end
        @(posedge clk_in);
        en  <= 3'h3;
        rgh <= 3'h1;
        rgl <= 3'h6;
        wreg(8'h1e, 16'h2000);
        check("gates", 6'h0a, {gh, gl});
        wreg(8'h1e, 16'h5000);
        check("gates", 6'h0e, {gh, gl});
    endtask
    task automatic t_prof();
        @(posedge clk_in);
        tin <= 4'ha;
        for (int i = 0; i < 3; i++)
        begin
            wreg(8'h1e, 16'(i) << 9);
            check("prof", i == 1 ? 16'h1a : 16'h0, {den, tout});
        end
    endtask
    initial
    begin
        {warn, flt, ot, clr, kill, tin} = '0;
        rst_in = 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        t_regs();
        t_warn();
        t_pd();
        t_pump();
        t_pwm();
        t_prof();
        complete_run();
    end
    initial
    begin
        repeat (100000) @(posedge clk_in);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
